// >>> bench/dcsd_fetch_model.sv
// Purpose: fetch-side model that presents first words to the decoder
// Assumes: bench raises req for one cycle per word, on a rising edge
// Notes:   idle cycles invert the shown word, so the last word returns every second idle cycle
`timescale 1ns/1ps
module dcsd_fetch_model (
  input  wire logic        clock,
  input  wire logic        req,
  input  wire logic [15:0] req_word,
  input  wire logic        req_cond,
  output logic             word_valid,
  output logic [15:0]      first_word,
  output logic             cond_true
);
  initial begin
    word_valid = 1'b0;
    first_word = 16'h0000;
    cond_true  = 1'b0;
  end
  // word and condition change only just after an edge
  always @(posedge clock) begin
    word_valid <= req;
    if (req) begin
      first_word <= req_word;
      cond_true  <= req_cond;
    end else begin
      first_word <= ~first_word;
      cond_true  <= ~cond_true;
    end
  end
endmodule

// >>> bench/dcsd_top_assertions.sv
// Purpose: port-level checks of the control/subtract decoder
// Assumes: results one edge after word_valid
// Notes:   bound to every dcsd_top instance
`timescale 1ns/1ps
module dcsd_top_assertions (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        word_valid,
  input wire logic [15:0] first_word,
  input wire logic        cond_true,
  input wire logic        dec_valid,
  input wire logic        dec_hit,
  input wire logic [4:0]  dec_op,
  input wire logic        dec_delayed,
  input wire logic        dec_irq_enable,
  input wire logic [1:0]  dec_words,
  input wire logic [2:0]  dec_cycles
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  answer_timing_a: assert property (word_valid |=> dec_valid)
    else $error("no result one cycle after a word");
  no_spurious_a: assert property (!word_valid |=> !dec_valid)
    else $error("result without a word");
  data_hold_a: assert property (!word_valid |=> $stable({dec_hit, dec_op,
    dec_words, dec_cycles, dec_delayed, dec_irq_enable}))
    else $error("outputs changed without a word");
  miss_zero_a: assert property (dec_valid && !dec_hit |->
    dec_words == 2'h0 && dec_cycles == 3'h0)
    else $error("miss with nonzero counts");
  reset_clear_a: assert property (disable iff (1'b0)
    reset |=> !dec_valid && dec_op == 5'h00 && dec_words == 2'h0)
    else $error("outputs not cleared by reset");
  branch_count_a: assert property (word_valid && first_word == 16'hf073 |=>
    dec_op == 5'h06 && dec_words == 2'h2 && dec_cycles == 3'h4)
    else $error("branch counts wrong");
  delay_select_a: assert property (word_valid && first_word == 16'hf273 |=>
    dec_delayed && dec_cycles == 3'h2)
    else $error("delayed branch counts wrong");
  cond_branch_a: assert property (word_valid && first_word[15:8] == 8'hf8
    && !first_word[7] |=> dec_cycles == ($past(cond_true) ? 3'h5 : 3'h3))
    else $error("conditional branch cycles wrong");
  stack_push_a: assert property (word_valid && first_word[15:9] == 7'h25
    && !first_word[7] |=> dec_words == 2'h1 && dec_cycles == 3'h1)
    else $error("push counts wrong");
  long_operand_a: assert property (word_valid && first_word[15:8] == 8'h8b
    && first_word[7] && first_word[3:2] == 2'b11 |=> dec_words == 2'h2 && dec_cycles == 3'h2)
    else $error("long operand not counted");
  fast_exit_a: assert property (word_valid && first_word == 16'hf69b |=>
    dec_cycles == 3'h1 && dec_irq_enable)
    else $error("delayed fast exit wrong");
  sub_no_delay_a: assert property (word_valid && first_word[15:10] == 6'h3c
    && first_word[7:4] == 4'h1 |=> !dec_delayed && dec_cycles == 3'h2)
    else $error("shifted immediate subtract took a delayed count");

  cover property (word_valid ##1 word_valid);
  cover property (dec_valid && dec_delayed);
  cover property (dec_valid && !dec_hit);
endmodule

bind dcsd_top dcsd_top_assertions u_chk (
  .clock(clock), .reset(reset), .word_valid(word_valid), .first_word(first_word),
  .cond_true(cond_true), .dec_valid(dec_valid), .dec_hit(dec_hit), .dec_op(dec_op),
  .dec_delayed(dec_delayed), .dec_irq_enable(dec_irq_enable), .dec_words(dec_words),
  .dec_cycles(dec_cycles)
);

// >>> bench/test_dsp_control_subtract_decoder.sv
// Purpose: self-checking bench of the control/subtract decoder
// Assumes: row = word, cond, op, words, cycles, {delayed, irq enable}
// Notes:   rows are sent back to back, then with gaps
`timescale 1ns/1ps
module test_dsp_control_subtract_decoder;
  logic        clock    = 1'b0;
  logic        reset    = 1'b1;
  logic        req      = 1'b0;
  logic [15:0] req_word = 16'h0000;
  logic        req_cond = 1'b0;
  logic        word_valid, cond_true, dec_valid, dec_hit, dec_delayed, dec_irq_enable;
  logic [15:0] first_word;
  logic [4:0]  dec_op;
  logic [1:0]  dec_words;
  logic [2:0]  dec_cycles;
  int          err_total   = 0;
  int          comparisons = 0;
  logic [39:0] exp_q [$];
  wire logic [12:0] outs = {dec_hit, dec_op, dec_words, dec_cycles, dec_delayed,
                            dec_irq_enable};
  logic [39:0] rows [$] = {
    40'hf013_0_01_2_2_0, 40'hf161_0_02_2_2_0, 40'hf43f_0_03_1_1_0,
    40'hf581_0_04_1_1_0, 40'h0f05_0_05_1_1_0,
    40'hf073_0_06_2_4_0, 40'hf273_0_06_2_2_2,
    40'hf4e2_0_07_1_6_0, 40'hf6e2_0_07_1_4_2,
    40'h6c05_1_08_2_4_0, 40'h6c05_0_08_2_2_0, 40'h6e05_1_08_2_2_2,
    40'hf803_1_09_2_5_0, 40'hf803_0_09_2_3_0, 40'hfa03_1_09_2_3_2,
    40'hf4e3_0_0a_1_6_0, 40'hf6e3_0_0a_1_4_2,
    40'hf074_0_0b_2_4_0, 40'hf274_0_0b_2_2_2,
    40'hf903_1_0c_2_5_0, 40'hf903_0_0c_2_3_0, 40'hfb03_1_0c_2_3_2,
    40'hf885_0_0d_2_4_0, 40'hf985_0_0e_2_4_0, 40'hfa85_0_0d_2_2_2,
    40'hfb85_0_0e_2_2_2,
    40'hf4e6_0_0f_1_6_0, 40'hf4e7_0_10_1_6_0, 40'hf6e7_0_10_1_4_2,
    40'hf4e4_0_11_1_6_0, 40'hf4e5_0_12_1_6_1, 40'hf6e5_0_12_1_4_3,
    40'h8b05_0_13_1_1_0, 40'h8a05_0_14_1_1_0, 40'h4b05_0_15_1_1_0,
    40'h4a05_0_16_1_1_0,
    40'hfc03_1_17_1_5_0, 40'hfc03_0_17_1_3_0, 40'hfe03_0_17_1_3_2,
    40'hf4eb_0_18_1_5_1, 40'hf6eb_0_18_1_3_3, 40'hf49b_0_19_1_3_1,
    40'hf69b_0_19_1_1_3,
    40'h4705_0_1a_1_1_0, 40'hec10_0_1b_1_1_0, 40'hf070_0_1c_2_2_0,
    40'hf072_0_1d_2_4_0, 40'hf272_0_1d_2_2_2,
    40'h0f8c_0_05_2_2_0, 40'h8b8f_0_13_2_2_0, 40'h6c8c_1_08_3_5_0,
    40'h4b8d_0_15_2_2_0, 40'h478e_0_1a_2_2_0, 40'h8a8c_0_14_1_1_0,
    40'hf4e1_0_00_0_0_0, 40'h0000_0_00_0_0_0,
    40'hf21a_0_01_2_2_0, 40'hf361_0_02_2_2_0
  };

  dcsd_fetch_model u_fetch (
    .clock(clock), .req(req), .req_word(req_word), .req_cond(req_cond),
    .word_valid(word_valid), .first_word(first_word), .cond_true(cond_true)
  );
  dcsd_top u_dut (
    .clock(clock), .reset(reset), .word_valid(word_valid), .first_word(first_word),
    .cond_true(cond_true), .dec_valid(dec_valid), .dec_hit(dec_hit), .dec_op(dec_op),
    .dec_delayed(dec_delayed), .dec_irq_enable(dec_irq_enable), .dec_words(dec_words),
    .dec_cycles(dec_cycles)
  );

  always #25 clock = ~clock;

  function automatic logic [12:0] xp(logic [39:0] e);
    return {|e[16:12], e[16:12], e[9:8], e[6:4], e[1:0]};
  endfunction

  task automatic cmp(logic [13:0] got, logic [13:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic send(logic [39:0] e);
    req      <= 1'b1;
    req_word <= e[39:24];
    req_cond <= e[20];
    exp_q.push_back(e);
    @(posedge clock);
  endtask

  task automatic complete_run;
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // results are checked in order, in the low phase
  always @(negedge clock) begin
    if (dec_valid === 1'b1) begin
      if (exp_q.size() == 0) cmp({1'b1, outs}, 14'h0000);
      else cmp({1'b1, outs}, {1'b1, xp(exp_q.pop_front())});
    end
  end

  initial begin
    #200000;
    err_total++;
    complete_run();
  end

  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    foreach (rows[i]) send(rows[i]);
    req <= 1'b0;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 6; i++) begin
      send(rows[i * 8]);
      req <= 1'b0;
      @(posedge clock);
    end
    repeat (4) @(posedge clock);
    #1;
    cmp({dec_valid, outs}, {1'b0, xp(rows[40])});
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    cmp({dec_valid, outs}, 14'h0000);
    @(posedge clock);
    reset <= 1'b0;
    send(rows[46]);
    req <= 1'b0;
    repeat (4) @(posedge clock);
    cmp(14'(exp_q.size()), 14'h0000);
    complete_run();
  end
endmodule

// >>> core/dcsd_dec_if.sv
// Purpose: carries one decoded first word between matcher and top
// Assumes: combinational matcher
// Notes:   op plus cycle-count alternatives
`timescale 1ns/1ps
interface dcsd_dec_if;
  logic [15:0]       word;
  dcsd_pkg::dcsd_op_t op;
  logic              hit;
  logic              mem_operand;
  logic              conditional;
  logic              delayed;
  logic [1:0]        words;
  logic [2:0]        cyc_norm;
  logic [2:0]        cyc_false;
  logic [2:0]        cyc_delay;
  modport matcher (input word, output op, hit, mem_operand, conditional, delayed, words,
                   cyc_norm, cyc_false, cyc_delay);
  modport user (output word, input op, hit, mem_operand, conditional, delayed, words,
                cyc_norm, cyc_false, cyc_delay);
endinterface

// >>> core/dcsd_match.sv
// Purpose: combinational opcode match of one first word
// Assumes: word stable in the cycle it is presented
// Notes:   more specific patterns are tested first
`timescale 1ns/1ps
module dcsd_match (
  dcsd_dec_if.matcher d
);

  function automatic logic fits(input logic [15:0] w, input logic [15:0] p,
                                input logic [15:0] m);
    fits = ((w & m) == p);
  endfunction

  always_comb begin
    d.op          = dcsd_pkg::DCSD_OP_NONE;
    d.mem_operand = 1'b0;
    d.conditional = 1'b0;
    d.words       = dcsd_pkg::W_ONE;
    d.cyc_norm    = dcsd_pkg::C_1;
    d.cyc_false   = dcsd_pkg::C_1;
    d.cyc_delay   = dcsd_pkg::C_1;
    d.delayed     = d.word[dcsd_pkg::Z_BIT];
    if (fits(d.word, dcsd_pkg::P_SUB_LK16, dcsd_pkg::M_FULLS)) begin
      d.op = dcsd_pkg::DCSD_OP_SUB_LK16;
      d.words = dcsd_pkg::W_TWO;
      d.cyc_norm = dcsd_pkg::C_2;
      // source select sits on the delay-bit position: no delayed form
      d.cyc_delay = dcsd_pkg::C_2;
    end else if (fits(d.word, dcsd_pkg::P_SUB_LK, dcsd_pkg::M_HI12)) begin
      d.op = dcsd_pkg::DCSD_OP_SUB_LK;
      d.words = dcsd_pkg::W_TWO;
      d.cyc_norm = dcsd_pkg::C_2;
      d.cyc_delay = dcsd_pkg::C_2;
    end else if (fits(d.word, dcsd_pkg::P_SUB_SMODE, dcsd_pkg::M_FULLS)) begin
      d.op = dcsd_pkg::DCSD_OP_SUB_SMODE;
    end else if (fits(d.word, dcsd_pkg::P_SUB_ACC, dcsd_pkg::M_SHACC)) begin
      d.op = dcsd_pkg::DCSD_OP_SUB_ACC;
    end else if (fits(d.word, dcsd_pkg::P_SUB_BORROW, dcsd_pkg::M_BYTED)) begin
      d.op = dcsd_pkg::DCSD_OP_SUB_BORROW;
      d.mem_operand = 1'b1;
    end else if (fits(d.word, dcsd_pkg::P_BRANCH, dcsd_pkg::M_FULLZ)) begin
      d.op = dcsd_pkg::DCSD_OP_BRANCH;
      d.words = dcsd_pkg::W_TWO;
      d.cyc_norm = dcsd_pkg::C_4;
      d.cyc_delay = dcsd_pkg::C_2;
    end else if (fits(d.word, dcsd_pkg::P_BR_ACC, dcsd_pkg::M_ACCZS)) begin
      d.op = dcsd_pkg::DCSD_OP_BR_ACC;
      d.cyc_norm = dcsd_pkg::C_6;
      d.cyc_delay = dcsd_pkg::C_4;
    end else if (fits(d.word, dcsd_pkg::P_LOOP_BNZ, dcsd_pkg::M_BYTEZ)) begin
      d.op = dcsd_pkg::DCSD_OP_LOOP_BNZ;
      d.words = dcsd_pkg::W_TWO;
      d.conditional = 1'b1;
      d.mem_operand = 1'b1;
      d.cyc_norm = dcsd_pkg::C_4;
      d.cyc_false = dcsd_pkg::C_2;
      d.cyc_delay = dcsd_pkg::C_2;
    end else if (fits(d.word, dcsd_pkg::P_FAR_JUMP, dcsd_pkg::M_FAR)) begin
      d.op = dcsd_pkg::DCSD_OP_FAR_JUMP;
      d.words = dcsd_pkg::W_TWO;
      d.cyc_norm = dcsd_pkg::C_4;
      d.cyc_delay = dcsd_pkg::C_2;
    end else if (fits(d.word, dcsd_pkg::P_FAR_CALL, dcsd_pkg::M_FAR)) begin
      d.op = dcsd_pkg::DCSD_OP_FAR_CALL;
      d.words = dcsd_pkg::W_TWO;
      d.cyc_norm = dcsd_pkg::C_4;
      d.cyc_delay = dcsd_pkg::C_2;
    end else if (fits(d.word, dcsd_pkg::P_COND_BR, dcsd_pkg::M_BYTEZ)) begin
      d.op = dcsd_pkg::DCSD_OP_COND_BR;
      d.words = dcsd_pkg::W_TWO;
      d.conditional = 1'b1;
      d.cyc_norm = dcsd_pkg::C_5;
      d.cyc_false = dcsd_pkg::C_3;
      d.cyc_delay = dcsd_pkg::C_3;
    end else if (fits(d.word, dcsd_pkg::P_CALL_ACC, dcsd_pkg::M_ACCZS)) begin
      d.op = dcsd_pkg::DCSD_OP_CALL_ACC;
      d.cyc_norm = dcsd_pkg::C_6;
      d.cyc_delay = dcsd_pkg::C_4;
    end else if (fits(d.word, dcsd_pkg::P_CALL, dcsd_pkg::M_FULLZ)) begin
      d.op = dcsd_pkg::DCSD_OP_CALL;
      d.words = dcsd_pkg::W_TWO;
      d.cyc_norm = dcsd_pkg::C_4;
      d.cyc_delay = dcsd_pkg::C_2;
    end else if (fits(d.word, dcsd_pkg::P_COND_CALL, dcsd_pkg::M_BYTEZ)) begin
      d.op = dcsd_pkg::DCSD_OP_COND_CALL;
      d.words = dcsd_pkg::W_TWO;
      d.conditional = 1'b1;
      d.cyc_norm = dcsd_pkg::C_5;
      d.cyc_false = dcsd_pkg::C_3;
      d.cyc_delay = dcsd_pkg::C_3;
    end else if (fits(d.word, dcsd_pkg::P_FAR_JACC, dcsd_pkg::M_ACCZS)) begin
      d.op = dcsd_pkg::DCSD_OP_FAR_JACC;
      d.cyc_norm = dcsd_pkg::C_6;
      d.cyc_delay = dcsd_pkg::C_4;
    end else if (fits(d.word, dcsd_pkg::P_FAR_CACC, dcsd_pkg::M_ACCZS)) begin
      d.op = dcsd_pkg::DCSD_OP_FAR_CACC;
      d.cyc_norm = dcsd_pkg::C_6;
      d.cyc_delay = dcsd_pkg::C_4;
    end else if (fits(d.word, dcsd_pkg::P_FAR_EXIT, dcsd_pkg::M_FULLZ)) begin
      d.op = dcsd_pkg::DCSD_OP_FAR_EXIT;
      d.cyc_norm = dcsd_pkg::C_6;
      d.cyc_delay = dcsd_pkg::C_4;
    end else if (fits(d.word, dcsd_pkg::P_FAR_EXITIE, dcsd_pkg::M_FULLZ)) begin
      d.op = dcsd_pkg::DCSD_OP_FAR_EXITIE;
      d.cyc_norm = dcsd_pkg::C_6;
      d.cyc_delay = dcsd_pkg::C_4;
    end else if (fits(d.word, dcsd_pkg::P_POP_DATA, dcsd_pkg::M_BYTE)) begin
      d.op = dcsd_pkg::DCSD_OP_POP_DATA;
      d.mem_operand = 1'b1;
    end else if (fits(d.word, dcsd_pkg::P_POP_MMR, dcsd_pkg::M_BYTE)) begin
      d.op = dcsd_pkg::DCSD_OP_POP_MMR;
    end else if (fits(d.word, dcsd_pkg::P_PUSH_DATA, dcsd_pkg::M_BYTE)) begin
      d.op = dcsd_pkg::DCSD_OP_PUSH_DATA;
      d.mem_operand = 1'b1;
    end else if (fits(d.word, dcsd_pkg::P_PUSH_MMR, dcsd_pkg::M_BYTE)) begin
      d.op = dcsd_pkg::DCSD_OP_PUSH_MMR;
    end else if (fits(d.word, dcsd_pkg::P_COND_EXIT, dcsd_pkg::M_BYTEZ)) begin
      d.op = dcsd_pkg::DCSD_OP_COND_EXIT;
      d.conditional = 1'b1;
      d.cyc_norm = dcsd_pkg::C_5;
      d.cyc_false = dcsd_pkg::C_3;
      d.cyc_delay = dcsd_pkg::C_3;
    end else if (fits(d.word, dcsd_pkg::P_EXIT_IE, dcsd_pkg::M_FULLZ)) begin
      d.op = dcsd_pkg::DCSD_OP_EXIT_IE;
      d.cyc_norm = dcsd_pkg::C_5;
      d.cyc_delay = dcsd_pkg::C_3;
    end else if (fits(d.word, dcsd_pkg::P_FAST_EXIT, dcsd_pkg::M_FULLZ)) begin
      d.op = dcsd_pkg::DCSD_OP_FAST_EXIT;
      d.cyc_norm = dcsd_pkg::C_3;
      d.cyc_delay = dcsd_pkg::C_1;
    end else if (fits(d.word, dcsd_pkg::P_REP_MEM, dcsd_pkg::M_BYTE)) begin
      d.op = dcsd_pkg::DCSD_OP_REP_MEM;
      d.mem_operand = 1'b1;
    end else if (fits(d.word, dcsd_pkg::P_REP_SHORT, dcsd_pkg::M_BYTE)) begin
      d.op = dcsd_pkg::DCSD_OP_REP_SHORT;
    end else if (fits(d.word, dcsd_pkg::P_REP_LONG, dcsd_pkg::M_FULL)) begin
      d.op = dcsd_pkg::DCSD_OP_REP_LONG;
      d.words = dcsd_pkg::W_TWO;
      d.cyc_norm = dcsd_pkg::C_2;
      d.cyc_delay = dcsd_pkg::C_2;
    end else if (fits(d.word, dcsd_pkg::P_BLOCK_LOOP, dcsd_pkg::M_FULLZ)) begin
      d.op = dcsd_pkg::DCSD_OP_BLOCK_LOOP;
      d.words = dcsd_pkg::W_TWO;
      d.cyc_norm = dcsd_pkg::C_4;
      d.cyc_delay = dcsd_pkg::C_2;
    end
    d.hit = (d.op != dcsd_pkg::DCSD_OP_NONE);
  end

endmodule

// >>> core/dcsd_pkg.sv
// Purpose: shared constants and types for the control/subtract decoder
// Assumes: 16-bit instruction words
// Notes:   patterns are first-word opcodes, masks mark the fixed bits
package dcsd_pkg;

  localparam int unsigned WORD_W = 16;

  typedef enum logic [4:0] {
    DCSD_OP_NONE       = 5'h00,
    DCSD_OP_SUB_LK     = 5'h01,
    DCSD_OP_SUB_LK16   = 5'h02,
    DCSD_OP_SUB_ACC    = 5'h03,
    DCSD_OP_SUB_SMODE  = 5'h04,
    DCSD_OP_SUB_BORROW = 5'h05,
    DCSD_OP_BRANCH     = 5'h06,
    DCSD_OP_BR_ACC     = 5'h07,
    DCSD_OP_LOOP_BNZ   = 5'h08,
    DCSD_OP_COND_BR    = 5'h09,
    DCSD_OP_CALL_ACC   = 5'h0a,
    DCSD_OP_CALL       = 5'h0b,
    DCSD_OP_COND_CALL  = 5'h0c,
    DCSD_OP_FAR_JUMP   = 5'h0d,
    DCSD_OP_FAR_CALL   = 5'h0e,
    DCSD_OP_FAR_JACC   = 5'h0f,
    DCSD_OP_FAR_CACC   = 5'h10,
    DCSD_OP_FAR_EXIT   = 5'h11,
    DCSD_OP_FAR_EXITIE = 5'h12,
    DCSD_OP_POP_DATA   = 5'h13,
    DCSD_OP_POP_MMR    = 5'h14,
    DCSD_OP_PUSH_DATA  = 5'h15,
    DCSD_OP_PUSH_MMR   = 5'h16,
    DCSD_OP_COND_EXIT  = 5'h17,
    DCSD_OP_EXIT_IE    = 5'h18,
    DCSD_OP_FAST_EXIT  = 5'h19,
    DCSD_OP_REP_MEM    = 5'h1a,
    DCSD_OP_REP_SHORT  = 5'h1b,
    DCSD_OP_REP_LONG   = 5'h1c,
    DCSD_OP_BLOCK_LOOP = 5'h1d
  } dcsd_op_t;

  typedef enum logic [2:0] {
    DCSD_ST_IDLE = 3'b001,
    DCSD_ST_WAIT = 3'b010,
    DCSD_ST_HOLD = 3'b100
  } dcsd_state_t;

  // delay-select bit position in control opcodes
  localparam int unsigned Z_BIT    = 9;
  localparam int unsigned COND_BIT = 7;
  // indirect flag and long-offset modes of the single operand field
  localparam int unsigned IND_BIT  = 7;
  localparam logic [3:0]  LONG_MOD0 = 4'hc;
  localparam logic [3:0]  LONG_MOD1 = 4'hd;
  localparam logic [3:0]  LONG_MOD2 = 4'he;
  localparam logic [3:0]  LONG_MOD3 = 4'hf;

  localparam logic [15:0] M_FULL  = 16'hffff;
  localparam logic [15:0] M_FULLZ = 16'hfdff;
  localparam logic [15:0] M_FULLS = 16'hfcff;
  localparam logic [15:0] M_ACCZS = 16'hfcff;
  localparam logic [15:0] M_HI12  = 16'hfcf0;
  localparam logic [15:0] M_SHACC = 16'hfce0;
  localparam logic [15:0] M_BYTE  = 16'hff00;
  localparam logic [15:0] M_BYTEZ = 16'hfd00;
  localparam logic [15:0] M_BYTED = 16'hfe00;
  localparam logic [15:0] M_FAR   = 16'hfd80;

  localparam logic [15:0] P_SUB_LK     = 16'hf010;
  localparam logic [15:0] P_SUB_LK16   = 16'hf061;
  localparam logic [15:0] P_SUB_ACC    = 16'hf420;
  localparam logic [15:0] P_SUB_SMODE  = 16'hf481;
  localparam logic [15:0] P_SUB_BORROW = 16'h0e00;
  localparam logic [15:0] P_BRANCH     = 16'hf073;
  localparam logic [15:0] P_BR_ACC     = 16'hf4e2;
  localparam logic [15:0] P_LOOP_BNZ   = 16'h6c00;
  localparam logic [15:0] P_COND_BR    = 16'hf800;
  localparam logic [15:0] P_CALL_ACC   = 16'hf4e3;
  localparam logic [15:0] P_CALL       = 16'hf074;
  localparam logic [15:0] P_COND_CALL  = 16'hf900;
  localparam logic [15:0] P_FAR_JUMP   = 16'hf880;
  localparam logic [15:0] P_FAR_CALL   = 16'hf980;
  localparam logic [15:0] P_FAR_JACC   = 16'hf4e6;
  localparam logic [15:0] P_FAR_CACC   = 16'hf4e7;
  localparam logic [15:0] P_FAR_EXIT   = 16'hf4e4;
  localparam logic [15:0] P_FAR_EXITIE = 16'hf4e5;
  localparam logic [15:0] P_POP_DATA   = 16'h8b00;
  localparam logic [15:0] P_POP_MMR    = 16'h8a00;
  localparam logic [15:0] P_PUSH_DATA  = 16'h4b00;
  localparam logic [15:0] P_PUSH_MMR   = 16'h4a00;
  localparam logic [15:0] P_COND_EXIT  = 16'hfc00;
  localparam logic [15:0] P_EXIT_IE    = 16'hf4eb;
  localparam logic [15:0] P_FAST_EXIT  = 16'hf49b;
  localparam logic [15:0] P_REP_MEM    = 16'h4700;
  localparam logic [15:0] P_REP_SHORT  = 16'hec00;
  localparam logic [15:0] P_REP_LONG   = 16'hf070;
  localparam logic [15:0] P_BLOCK_LOOP = 16'hf072;

  localparam logic [1:0] W_ONE = 2'h1;
  localparam logic [1:0] W_TWO = 2'h2;
  localparam logic [2:0] C_1 = 3'h1;
  localparam logic [2:0] C_2 = 3'h2;
  localparam logic [2:0] C_3 = 3'h3;
  localparam logic [2:0] C_4 = 3'h4;
  localparam logic [2:0] C_5 = 3'h5;
  localparam logic [2:0] C_6 = 3'h6;

endpackage

// >>> core/dcsd_top.sv
// Purpose: registered decode of the subtract and program-control slice
// Assumes: fetch presents one first word per valid pulse, condition result given with it
// Notes:   results stand one cycle after the request, as a one-cycle valid
`timescale 1ns/1ps
// Behaviour
// - shifted long immediate subtract: 2 words, 2 cycles
// - long immediate shifted 16 subtract: 2/2
// - shifted accumulator subtract: 1 word, 1 cycle
// - accumulator shifted by shift mode subtract: 1/1
// - memory subtract with borrow: 1/1
// - unconditional branch: 2 words, 4 or 2 delayed
// - branch to accumulator: 1 word, 6 or 4
// - loop branch nonzero: 4 taken, 2 otherwise
// - conditional branch: 5 true, 3 false/delayed
// - call to accumulator: 1 word, 6 or 4
// - unconditional call: 2 words, 4 or 2
// - conditional call: 5 true, 3 false/delayed
// - far jump and far call: 2 words, 4/2
// - far jump/call to accumulator: 1 word, 6/4
// - far exits, plain and irq enable: 6/4
// - stack push and pop forms: 1/1
// - conditional exit: 5 true, 3 false/delayed
// - exit irq enable 5/3, fast 3/1
// - single repeat: memory, short, long immediate forms
// - block loop set-up: 2 words, 4 or 2
// - long-offset or absolute operand adds word, cycle
module dcsd_top (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        word_valid,
  input  wire logic [15:0] first_word,
  input  wire logic        cond_true,
  output logic             dec_valid,
  output logic             dec_hit,
  output logic [4:0]       dec_op,
  output logic             dec_delayed,
  output logic             dec_irq_enable,
  output logic [1:0]       dec_words,
  output logic [2:0]       dec_cycles
);

  dcsd_dec_if d ();

  dcsd_match u_match (
    .d (d)
  );

  logic       long_mode;
  logic       use_delay;
  logic [2:0] base_cyc;
  logic [1:0] words_d;
  logic [2:0] cycles_d;
  logic       irq_en_d;

  assign d.word = first_word;

  always_comb begin
    long_mode = d.mem_operand && first_word[dcsd_pkg::IND_BIT] &&
                ((first_word[3:0] == dcsd_pkg::LONG_MOD0) ||
                 (first_word[3:0] == dcsd_pkg::LONG_MOD1) ||
                 (first_word[3:0] == dcsd_pkg::LONG_MOD2) ||
                 (first_word[3:0] == dcsd_pkg::LONG_MOD3));
    use_delay = (d.cyc_delay != d.cyc_norm) && d.delayed;
    if (use_delay) begin
      base_cyc = d.cyc_delay;
    end else if (d.conditional && !cond_true) begin
      base_cyc = d.cyc_false;
    end else begin
      base_cyc = d.cyc_norm;
    end
    words_d  = d.words + {1'b0, long_mode};
    cycles_d = base_cyc + {2'h0, long_mode};
    irq_en_d = (d.op == dcsd_pkg::DCSD_OP_FAR_EXITIE) || (d.op == dcsd_pkg::DCSD_OP_EXIT_IE) ||
               (d.op == dcsd_pkg::DCSD_OP_FAST_EXIT);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= word_valid;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      dec_hit        <= 1'b0;
      dec_op         <= 5'h00;
      dec_delayed    <= 1'b0;
      dec_irq_enable <= 1'b0;
      dec_words      <= 2'h0;
      dec_cycles     <= 3'h0;
    end else if (word_valid) begin
      dec_hit        <= d.hit;
      dec_op         <= d.op;
      dec_delayed    <= use_delay;
      dec_irq_enable <= irq_en_d;
      dec_words      <= d.hit ? words_d : 2'h0;
      dec_cycles     <= d.hit ? cycles_d : 3'h0;
    end
  end

endmodule
